/* inc/cwd_pkg.sv */
package cwd_pkg;
  // ----------------------------------------------------------------
  // register map (word indices on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CONFIG_WORD = 4'h0;
  localparam logic [3:0] ADDR_PART_IDENTITY = 4'h1;
  localparam logic [3:0] ADDR_SILICON_REVISION = 4'h2;
  localparam logic [3:0] ADDR_PIN_LOCK_CTRL = 4'h3;
  localparam logic [3:0] ADDR_PIN_SELECT = 4'h4;
  localparam logic [3:0] ADDR_SLEEP_CTRL = 4'h5;
  localparam logic [3:0] ADDR_UNLOCK_KEY = 4'h6;

  // ----------------------------------------------------------------
  // configuration word fields
  // ----------------------------------------------------------------
  localparam int CFG_W = 24;
  localparam int POS_ONE_WAY = 15;
  localparam int POS_TWO_WIRE_LOC = 14;
  localparam int POS_PLL_LO = 10;
  localparam int POS_RSVD9 = 9;
  localparam int POS_DS_SW_CTRL = 8;
  localparam int POS_DS_WDT_EN = 7;
  localparam int POS_DS_BOR_EN = 6;
  localparam int POS_DS_WDT_CLK = 5;
  localparam int POS_DS_PS_LO = 0;
  localparam logic [7:0] UNIMPL_ONES = 8'hff;
  localparam logic [15:0] CFG_ERASED = 16'hffff;

  // ----------------------------------------------------------------
  // pll codes and postscaler base
  // ----------------------------------------------------------------
  localparam logic [3:0] PLL_OFF = 4'hf;
  localparam logic [3:0] PLL_X8 = 4'he;
  localparam logic [3:0] PLL_X6 = 4'hd;
  localparam logic [3:0] PLL_X4 = 4'hc;
  localparam logic [5:0] PS_BASE_LOG2 = 6'h05;

  // ----------------------------------------------------------------
  // unlock sequence keys and pin-select reset value
  // ----------------------------------------------------------------
  localparam logic [15:0] KEY_FIRST = 16'h0046;
  localparam logic [15:0] KEY_SECOND = 16'h0057;
  localparam logic [15:0] PIN_SEL_RESET = 16'h0000;

  typedef enum logic [1:0] {CWD_PLL_NONE, CWD_PLL_4X, CWD_PLL_6X, CWD_PLL_8X} cwd_pll_t;
  typedef enum {CWD_LOCKED, CWD_KEY1, CWD_OPEN} cwd_unlock_t;
endpackage : cwd_pkg

/* hdl/cwd_field_decode.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// pure decode of the held configuration word into control outputs
// ------------------------------------------------------------------
module cwd_field_decode (
  input wire logic [15:0] cfg_i,
  output cwd_pkg::cwd_pll_t pll_mode_o,
  output logic pll_code_bad_o,
  output logic [5:0] ps_log2_o,
  output logic wdt_clk_low_power_rc_clock_o,
  output logic two_wire_primary_o
);
  // pll decode; reserved codes fall back to pll off and are flagged
  always_comb begin
    pll_code_bad_o = 1'b0;
    unique case (cfg_i[cwd_pkg::POS_PLL_LO +: 4])
      cwd_pkg::PLL_OFF: pll_mode_o = cwd_pkg::CWD_PLL_NONE; // [R04]
      cwd_pkg::PLL_X8: pll_mode_o = cwd_pkg::CWD_PLL_8X; // [R04]
      cwd_pkg::PLL_X6: pll_mode_o = cwd_pkg::CWD_PLL_6X; // [R04]
      cwd_pkg::PLL_X4: pll_mode_o = cwd_pkg::CWD_PLL_4X; // [R04]
      default: begin
        pll_mode_o = cwd_pkg::CWD_PLL_NONE;
        pll_code_bad_o = 1'b1; // [R04]
      end
    endcase
  end

  // divide ratio is 2^(code+5): 1:32 up to 1:2^36
  assign ps_log2_o = cwd_pkg::PS_BASE_LOG2 + {1'b0, cfg_i[cwd_pkg::POS_DS_PS_LO +: 5]}; // [R10]
  assign wdt_clk_low_power_rc_clock_o = cfg_i[cwd_pkg::POS_DS_WDT_CLK]; // [R09]
  assign two_wire_primary_o = cfg_i[cwd_pkg::POS_TWO_WIRE_LOC]; // [R03]
endmodule : cwd_field_decode

/* hdl/cwd_config_bank.sv */
`timescale 1ns/1ps
// Function
// R01 - one-way option set: pin-map lock sets once after unlock; then pin writes refused
// R02 - one-way option clear: lock sets and clears freely, each after unlock sequence
// R03 - two-wire bus on primary pins when select bit is 1, else alternate pins
// R04 - pll code 1111 off, 1110 8x, 1101 6x, 1100 4x; lower codes reserved
// R05 - programmer keeps reserved bit 9 of the configuration word at 1
// R06 - deep sleep allowed under request bit only when software control bit is 1
// R07 - deep sleep watchdog runs only when its enable bit is 1
// R08 - brown-out reset in deep sleep follows its bit; other sleeps keep it
// R09 - deep sleep watchdog clock: low-power rc when 1, secondary oscillator when 0
// R10 - postscaler code doubles ratio each step, 1:32 at 00000
// R11 - upper eight bits of config word and identity read as ones
// R12 - identity register read-only: family code high byte, part code low byte
// R13 - revision register read-only: 4-bit revision low, higher bits zero
// R14 - configuration captured from storage at reset and held until next reset
module cwd_config_bank #(
  parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'h3c, // arbitrary value
  parameter logic [3:0] REVISION_CODE = 4'h1 // arbitrary value
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [15:0] nvm_word_i,
  input wire logic [3:0] addr_i,
  input wire logic [23:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [23:0] rdata_o,
  input wire logic sleep_mode_i,
  output logic pin_map_lock_o,
  output logic [15:0] pin_select_o,
  output logic two_wire_primary_o,
  output logic [1:0] pll_multiplier_select_o,
  output logic pll_code_bad_o,
  output logic deep_sleep_active_o,
  output logic deep_sleep_watchdog_run_o,
  output logic deep_sleep_watchdog_clock_select_o,
  output logic [5:0] deep_sleep_watchdog_postscale_o,
  output logic brownout_reset_enable_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic loaded;
    logic [15:0] cfg;
    cwd_pkg::cwd_unlock_t unlock;
    logic lock;
    logic lock_was_set;
    logic [15:0] pin_sel;
    logic ds_request;
    logic [23:0] rdata;
  } cwd_state_t;

  cwd_state_t st;
  cwd_state_t next_st;

  cwd_pkg::cwd_pll_t pll_mode;
  logic [5:0] ps_log2;
  logic one_way;
  logic lock_write_ok;
  logic pin_write_ok;

  // ----------------------------------------------------------------
  // decode of the held word
  // ----------------------------------------------------------------
  cwd_field_decode u_decode (
    .cfg_i(st.cfg),
    .pll_mode_o(pll_mode),
    .pll_code_bad_o(pll_code_bad_o),
    .ps_log2_o(ps_log2),
    .wdt_clk_low_power_rc_clock_o(deep_sleep_watchdog_clock_select_o),
    .two_wire_primary_o(two_wire_primary_o)
  );

  assign one_way = st.cfg[cwd_pkg::POS_ONE_WAY];
  // a lock change needs an open unlock window; one-way mode forbids any change after set
  assign lock_write_ok = (st.unlock == cwd_pkg::CWD_OPEN) &&
                         !(one_way && st.lock_was_set); // [R01] [R02]
  // pin select writes only while the lock is clear
  assign pin_write_ok = !st.lock; // [R01]

  // read mux; unimplemented top byte of identity and config reads ones
  function automatic logic [23:0] read_value(input logic [3:0] a, input cwd_state_t s);
    logic [23:0] v;
    v = 24'h000000;
    unique case (a)
      cwd_pkg::ADDR_CONFIG_WORD: v = {cwd_pkg::UNIMPL_ONES, s.cfg}; // [R11]
      cwd_pkg::ADDR_PART_IDENTITY: v = {cwd_pkg::UNIMPL_ONES, FAMILY_CODE, PART_CODE}; // [R11] [R12]
      cwd_pkg::ADDR_SILICON_REVISION: v = {20'h00000, REVISION_CODE}; // [R13]
      cwd_pkg::ADDR_PIN_LOCK_CTRL: v = {22'h0, s.lock_was_set, s.lock};
      cwd_pkg::ADDR_PIN_SELECT: v = {8'h00, s.pin_sel};
      cwd_pkg::ADDR_SLEEP_CTRL: v = {23'h0, s.ds_request};
      default: v = 24'h000000;
    endcase
    return v;
  endfunction : read_value

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // capture once after reset; only reset reloads it
    if (!st.loaded) begin
      next_st.cfg = nvm_word_i; // [R14]
      next_st.loaded = 1'b1;
    end
    // rdata valid only in the cycle after the read strobe
    next_st.rdata = rd_i ? read_value(addr_i, st) : 24'h000000;
    if (wr_i) begin
      // any write other than the next key closes the window
      if (addr_i == cwd_pkg::ADDR_UNLOCK_KEY && wdata_i[15:0] == cwd_pkg::KEY_FIRST) begin
        next_st.unlock = cwd_pkg::CWD_KEY1;
      end else if (addr_i == cwd_pkg::ADDR_UNLOCK_KEY && st.unlock == cwd_pkg::CWD_KEY1 &&
                   wdata_i[15:0] == cwd_pkg::KEY_SECOND) begin
        next_st.unlock = cwd_pkg::CWD_OPEN;
      end else begin
        next_st.unlock = cwd_pkg::CWD_LOCKED;
      end
      unique case (addr_i)
        cwd_pkg::ADDR_PIN_LOCK_CTRL: begin
          if (lock_write_ok) begin
            next_st.lock = wdata_i[0]; // [R01] [R02]
            next_st.lock_was_set = st.lock_was_set | wdata_i[0];
          end
        end
        cwd_pkg::ADDR_PIN_SELECT: begin
          if (pin_write_ok) begin
            next_st.pin_sel = wdata_i[15:0]; // [R01]
          end
        end
        cwd_pkg::ADDR_SLEEP_CTRL: next_st.ds_request = wdata_i[0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers; reset reloads the configuration word
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st.loaded <= 1'b0;
      st.cfg <= cwd_pkg::CFG_ERASED;
      st.unlock <= cwd_pkg::CWD_LOCKED;
      st.lock <= 1'b0;
      st.lock_was_set <= 1'b0;
      st.pin_sel <= cwd_pkg::PIN_SEL_RESET;
      st.ds_request <= 1'b0;
      st.rdata <= 24'h000000;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o = st.rdata;
  assign pin_map_lock_o = st.lock;
  assign pin_select_o = st.pin_sel;
  assign pll_multiplier_select_o = pll_mode;
  assign deep_sleep_watchdog_postscale_o = ps_log2;
  // deep sleep needs the software control bit as well as the request
  assign deep_sleep_active_o = st.cfg[cwd_pkg::POS_DS_SW_CTRL] & st.ds_request; // [R06]
  assign deep_sleep_watchdog_run_o = st.cfg[cwd_pkg::POS_DS_WDT_EN] & deep_sleep_active_o; // [R07]
  // brown-out stays on in other sleep modes; deep sleep follows the bit
  assign brownout_reset_enable_o = deep_sleep_active_o ?
                                   st.cfg[cwd_pkg::POS_DS_BOR_EN] : 1'b1; // [R08]

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_pin_write_refused: assert property (@(posedge mclk_i) disable iff (rst_i) // [R01]
    (wr_i && addr_i == cwd_pkg::ADDR_PIN_SELECT && st.lock) |=> $stable(pin_select_o))
    else $error("pin select changed while locked");
  a_one_way_hold: assert property (@(posedge mclk_i) disable iff (rst_i) // [R01]
    (one_way && st.lock_was_set && st.loaded) |=> $stable(pin_map_lock_o))
    else $error("one-way lock changed after set");
  a_lock_needs_key: assert property (@(posedge mclk_i) disable iff (rst_i) // [R02]
    (st.unlock != cwd_pkg::CWD_OPEN) |=> $stable(pin_map_lock_o))
    else $error("lock changed without unlock");
  a_pll_x8_decode: assert property (@(posedge mclk_i) disable iff (rst_i) // [R04]
    (st.cfg[cwd_pkg::POS_PLL_LO +: 4] == cwd_pkg::PLL_X8) |-> pll_mode == cwd_pkg::CWD_PLL_8X)
    else $error("pll 8x decode wrong");
  a_ds_gate: assert property (@(posedge mclk_i) disable iff (rst_i) // [R06]
    !st.cfg[cwd_pkg::POS_DS_SW_CTRL] |-> !deep_sleep_active_o)
    else $error("deep sleep without control bit");
  a_wdt_gate: assert property (@(posedge mclk_i) disable iff (rst_i) // [R07]
    !st.cfg[cwd_pkg::POS_DS_WDT_EN] |-> !deep_sleep_watchdog_run_o)
    else $error("watchdog runs while disabled");
  a_bor_other: assert property (@(posedge mclk_i) disable iff (rst_i) // [R08]
    (sleep_mode_i && !deep_sleep_active_o) |-> brownout_reset_enable_o)
    else $error("brown-out off outside deep sleep");
  a_ps_base: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
    (st.cfg[4:0] == 5'h00) |-> ps_log2 == 6'h05)
    else $error("postscaler base not 1:32");
  a_cfg_ones: assert property (@(posedge mclk_i) disable iff (rst_i) // [R11]
    (rd_i && addr_i == cwd_pkg::ADDR_CONFIG_WORD) |=> rdata_o[23:16] == 8'hff)
    else $error("config upper byte not ones");
  a_rev_read: assert property (@(posedge mclk_i) disable iff (rst_i) // [R13]
    (rd_i && addr_i == cwd_pkg::ADDR_SILICON_REVISION) |=> rdata_o == {20'h00000, REVISION_CODE})
    else $error("revision read wrong");
  a_id_read: assert property (@(posedge mclk_i) disable iff (rst_i) // [R12]
    (rd_i && addr_i == cwd_pkg::ADDR_PART_IDENTITY) |=> rdata_o[15:0] == {FAMILY_CODE, PART_CODE})
    else $error("identity read wrong");
  a_cfg_held: assert property (@(posedge mclk_i) disable iff (rst_i) // [R14]
    st.loaded |=> $stable(st.cfg))
    else $error("config word changed while running");
  a_cfg_ts_loc: assert property (@(posedge mclk_i) disable iff (rst_i) // [R03]
    two_wire_primary_o == st.cfg[cwd_pkg::POS_TWO_WIRE_LOC])
    else $error("two-wire location wrong");
  a_clk_sel: assert property (@(posedge mclk_i) disable iff (rst_i) // [R09]
    deep_sleep_watchdog_clock_select_o == st.cfg[cwd_pkg::POS_DS_WDT_CLK])
    else $error("watchdog clock select wrong");

  // ----------------------------------------------------------------
  // assertions: decode of the held word
  // ----------------------------------------------------------------
  // every legal pll code maps to its own mode, reserved ones are flagged
  a_pll_x6_decode: assert property (@(posedge mclk_i) disable iff (rst_i) // [R04]
    (st.cfg[cwd_pkg::POS_PLL_LO +: 4] == cwd_pkg::PLL_X6) |-> pll_mode == cwd_pkg::CWD_PLL_6X)
    else $error("pll 6x decode wrong");
  a_pll_x4_decode: assert property (@(posedge mclk_i) disable iff (rst_i) // [R04]
    (st.cfg[cwd_pkg::POS_PLL_LO +: 4] == cwd_pkg::PLL_X4) |-> pll_mode == cwd_pkg::CWD_PLL_4X)
    else $error("pll 4x decode wrong");
  a_pll_off_decode: assert property (@(posedge mclk_i) disable iff (rst_i) // [R04]
    (st.cfg[cwd_pkg::POS_PLL_LO +: 4] == cwd_pkg::PLL_OFF) |-> pll_mode == cwd_pkg::CWD_PLL_NONE)
    else $error("pll off decode wrong");
  a_pll_reserved_flag: assert property (@(posedge mclk_i) disable iff (rst_i) // [R04]
    (st.cfg[cwd_pkg::POS_PLL_LO +: 4] < cwd_pkg::PLL_X4) |->
    (pll_code_bad_o && pll_mode == cwd_pkg::CWD_PLL_NONE))
    else $error("reserved pll code not flagged");
  a_pll_legal_clean: assert property (@(posedge mclk_i) disable iff (rst_i) // [R04]
    (st.cfg[cwd_pkg::POS_PLL_LO +: 4] >= cwd_pkg::PLL_X4) |-> !pll_code_bad_o)
    else $error("legal pll code flagged");
  // postscaler top end point and a middle step of the doubling ladder
  a_ps_top: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
    (st.cfg[4:0] == 5'h1f) |-> ps_log2 == 6'h24)
    else $error("postscaler top not 1:2^36");
  a_ps_mid: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
    (st.cfg[4:0] == 5'h0a) |-> ps_log2 == 6'h0f)
    else $error("postscaler step wrong");
  a_two_wire_alt: assert property (@(posedge mclk_i) disable iff (rst_i) // [R03]
    !st.cfg[cwd_pkg::POS_TWO_WIRE_LOC] |-> !two_wire_primary_o)
    else $error("alternate pins not chosen");
  // sleep controls must follow their bits both ways, not only gate off
  a_ds_follows: assert property (@(posedge mclk_i) disable iff (rst_i) // [R06]
    (st.cfg[cwd_pkg::POS_DS_SW_CTRL] && st.ds_request) |-> deep_sleep_active_o)
    else $error("deep sleep request ignored");
  a_wdt_follows: assert property (@(posedge mclk_i) disable iff (rst_i) // [R07]
    (deep_sleep_active_o && st.cfg[cwd_pkg::POS_DS_WDT_EN]) |-> deep_sleep_watchdog_run_o)
    else $error("watchdog idle while enabled");
  a_bor_deep: assert property (@(posedge mclk_i) disable iff (rst_i) // [R08]
    deep_sleep_active_o |-> brownout_reset_enable_o == st.cfg[cwd_pkg::POS_DS_BOR_EN])
    else $error("brown-out in deep sleep wrong");

  // ----------------------------------------------------------------
  // assertions: lock, unlock and register port
  // ----------------------------------------------------------------
  // an allowed lock write must land, or software cannot rely on the lock
  a_lock_free_write: assert property (@(posedge mclk_i) disable iff (rst_i) // [R02]
    (wr_i && addr_i == cwd_pkg::ADDR_PIN_LOCK_CTRL && st.unlock == cwd_pkg::CWD_OPEN &&
    !one_way) |=> pin_map_lock_o == $past(wdata_i[0]))
    else $error("free lock write lost");
  a_one_way_first: assert property (@(posedge mclk_i) disable iff (rst_i) // [R01]
    (wr_i && addr_i == cwd_pkg::ADDR_PIN_LOCK_CTRL && st.unlock == cwd_pkg::CWD_OPEN &&
    one_way && !st.lock_was_set) |=> pin_map_lock_o == $past(wdata_i[0]))
    else $error("first one-way lock write lost");
  a_lock_sticky: assert property (@(posedge mclk_i) disable iff (rst_i) // [R01]
    st.lock |-> st.lock_was_set)
    else $error("lock set without history");
  a_pin_write_open: assert property (@(posedge mclk_i) disable iff (rst_i) // [R01]
    (wr_i && addr_i == cwd_pkg::ADDR_PIN_SELECT && !st.lock) |=>
    pin_select_o == $past(wdata_i[15:0]))
    else $error("pin select write lost");
  a_key_opens: assert property (@(posedge mclk_i) disable iff (rst_i) // [R02]
    (wr_i && addr_i == cwd_pkg::ADDR_UNLOCK_KEY && st.unlock == cwd_pkg::CWD_KEY1 &&
    wdata_i[15:0] == cwd_pkg::KEY_SECOND) |=> st.unlock == cwd_pkg::CWD_OPEN)
    else $error("key pair did not open");
  // any other write shuts the window so a stray write cannot ride on it
  a_unlock_close: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_i && addr_i != cwd_pkg::ADDR_UNLOCK_KEY) |=> st.unlock == cwd_pkg::CWD_LOCKED)
    else $error("unlock window left open");
  a_id_ones: assert property (@(posedge mclk_i) disable iff (rst_i) // [R11]
    (rd_i && addr_i == cwd_pkg::ADDR_PART_IDENTITY) |=> rdata_o[23:16] == 8'hff)
    else $error("identity upper byte not ones");
  a_cfg_read_low: assert property (@(posedge mclk_i) disable iff (rst_i) // [R14]
    (rd_i && addr_i == cwd_pkg::ADDR_CONFIG_WORD) |=> rdata_o[15:0] == $past(st.cfg))
    else $error("config read does not match held word");
  a_rdata_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
    !rd_i |=> rdata_o == 24'h000000)
    else $error("read data outside read cycle");

  c_unlock_open: cover property (@(posedge mclk_i) disable iff (rst_i)
    st.unlock == cwd_pkg::CWD_OPEN);
  c_lock_set: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(pin_map_lock_o));
  c_lock_clear: cover property (@(posedge mclk_i) disable iff (rst_i) $fell(pin_map_lock_o));
  c_deep_sleep: cover property (@(posedge mclk_i) disable iff (rst_i) deep_sleep_active_o);
  c_pin_refused: cover property (@(posedge mclk_i) disable iff (rst_i)
    wr_i && addr_i == cwd_pkg::ADDR_PIN_SELECT && st.lock);
endmodule : cwd_config_bank

/* dv/config_word_and_id_decode_tb_top.sv */
`timescale 1ns/1ps
module config_word_and_id_decode_tb_top;
  // ----------------------------------------------------------------
  // clock, design hookup and bookkeeping
  // ----------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic rst_i, wr_i, rd_i, sleep_mode_i;
  logic [15:0] nvm_word_i;
  logic [3:0] addr_i;
  logic [23:0] wdata_i, rdata_o, rv;
  logic pin_map_lock_o, two_wire_primary_o, pll_code_bad_o, deep_sleep_active_o;
  logic deep_sleep_watchdog_run_o, deep_sleep_watchdog_clock_select_o, brownout_reset_enable_o;
  logic [15:0] pin_select_o;
  logic [1:0] pll_multiplier_select_o;
  logic [5:0] deep_sleep_watchdog_postscale_o;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [3:0] codes [6] = '{4'hf, 4'he, 4'hd, 4'hc, 4'hb, 4'h0};
  cwd_pkg::cwd_pll_t modes [6] = '{cwd_pkg::CWD_PLL_NONE, cwd_pkg::CWD_PLL_8X,
    cwd_pkg::CWD_PLL_6X, cwd_pkg::CWD_PLL_4X, cwd_pkg::CWD_PLL_NONE, cwd_pkg::CWD_PLL_NONE};
  logic bads [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [4:0] ps;

  always #2.5 mclk_i = ~mclk_i;

  cwd_config_bank uut (
    .mclk_i(mclk_i), .rst_i(rst_i), .nvm_word_i(nvm_word_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sleep_mode_i(sleep_mode_i), .pin_map_lock_o(pin_map_lock_o),
    .pin_select_o(pin_select_o), .two_wire_primary_o(two_wire_primary_o),
    .pll_multiplier_select_o(pll_multiplier_select_o), .pll_code_bad_o(pll_code_bad_o),
    .deep_sleep_active_o(deep_sleep_active_o),
    .deep_sleep_watchdog_run_o(deep_sleep_watchdog_run_o),
    .deep_sleep_watchdog_clock_select_o(deep_sleep_watchdog_clock_select_o),
    .deep_sleep_watchdog_postscale_o(deep_sleep_watchdog_postscale_o),
    .brownout_reset_enable_o(brownout_reset_enable_o)
  );

  // ----------------------------------------------------------------
  // bus tasks: one idle cycle after each strobe keeps drivers race-free
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [23:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge mclk_i);
  endtask : rd

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic unlock();
    wr(cwd_pkg::ADDR_UNLOCK_KEY, {8'h00, cwd_pkg::KEY_FIRST});
    wr(cwd_pkg::ADDR_UNLOCK_KEY, {8'h00, cwd_pkg::KEY_SECOND});
  endtask : unlock

  // config word is only taken at the first edge after reset release
  task automatic boot(input logic [15:0] w);
    rst_i <= 1'b1;
    nvm_word_i <= w;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask : boot

  task automatic final_report();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // hang guard, far above the 87 cycles the tests need
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles > 5000) begin
      error_cnt++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; sleep_mode_i = 1'b0;
    nvm_word_i = 16'h0000; addr_i = 4'h0; wdata_i = 24'h000000;
    // one-way lock, primary pins, 8x, deep sleep allowed, wdt on, bor off in deep sleep
    boot(16'hfba0);
    rd(cwd_pkg::ADDR_CONFIG_WORD, rv); chk("config word", rv, 24'hfffba0);
    rd(cwd_pkg::ADDR_PART_IDENTITY, rv); chk("identity", rv, 24'hff5a3c);
    wr(cwd_pkg::ADDR_PART_IDENTITY, 24'h000000);
    rd(cwd_pkg::ADDR_PART_IDENTITY, rv); chk("identity after write", rv, 24'hff5a3c);
    wr(cwd_pkg::ADDR_SILICON_REVISION, 24'hffffff);
    rd(cwd_pkg::ADDR_SILICON_REVISION, rv); chk("revision", rv, 24'h000001);
    rd(4'hf, rv); chk("unmapped read", rv, 24'h000000);
    chk("primary pins", 24'(two_wire_primary_o), 24'h000001);
    chk("wdt clock", 24'(deep_sleep_watchdog_clock_select_o), 24'h000001);
    wr(cwd_pkg::ADDR_SLEEP_CTRL, 24'h000001);
    chk("deep sleep on", 24'(deep_sleep_active_o), 24'h000001);
    chk("wdt run", 24'(deep_sleep_watchdog_run_o), 24'h000001);
    chk("bor deep sleep", 24'(brownout_reset_enable_o), 24'h000000);
    wr(cwd_pkg::ADDR_SLEEP_CTRL, 24'h000000);
    sleep_mode_i <= 1'b1;
    @(posedge mclk_i);
    chk("bor other sleep", 24'(brownout_reset_enable_o), 24'h000001);
    sleep_mode_i <= 1'b0;
    // lock write without the key sequence is ignored
    wr(cwd_pkg::ADDR_PIN_LOCK_CTRL, 24'h000001);
    chk("lock no key", 24'(pin_map_lock_o), 24'h000000);
    wr(cwd_pkg::ADDR_PIN_SELECT, 24'h001234);
    chk("pin select open", 24'(pin_select_o), 24'h001234);
    unlock();
    wr(cwd_pkg::ADDR_PIN_LOCK_CTRL, 24'h000001);
    chk("lock set", 24'(pin_map_lock_o), 24'h000001);
    wr(cwd_pkg::ADDR_PIN_SELECT, 24'h00abcd);
    chk("pin select refused", 24'(pin_select_o), 24'h001234);
    unlock();
    wr(cwd_pkg::ADDR_PIN_LOCK_CTRL, 24'h000000);
    chk("one-way stays set", 24'(pin_map_lock_o), 24'h000001);
    // free lock, alternate pins, 4x, deep sleep barred, wdt off, low_power_rc_clock off, top postscale
    boot(16'h325f);
    nvm_word_i <= 16'h0000;
    chk("alternate pins", 24'(two_wire_primary_o), 24'h000000);
    chk("wdt clock secondary_oscillator", 24'(deep_sleep_watchdog_clock_select_o), 24'h000000);
    chk("postscale top", 24'(deep_sleep_watchdog_postscale_o), 24'h000024);
    wr(cwd_pkg::ADDR_SLEEP_CTRL, 24'h000001);
    chk("deep sleep barred", 24'(deep_sleep_active_o), 24'h000000);
    chk("wdt idle", 24'(deep_sleep_watchdog_run_o), 24'h000000);
    chk("bor kept", 24'(brownout_reset_enable_o), 24'h000001);
    rd(cwd_pkg::ADDR_CONFIG_WORD, rv); chk("config held", rv, 24'hff325f);
    chk("reserved bit kept", 24'(rv[9]), 24'h000001);
    unlock();
    wr(cwd_pkg::ADDR_PIN_LOCK_CTRL, 24'h000001);
    chk("free lock set", 24'(pin_map_lock_o), 24'h000001);
    unlock();
    wr(cwd_pkg::ADDR_PIN_LOCK_CTRL, 24'h000000);
    chk("free lock clear", 24'(pin_map_lock_o), 24'h000000);
    wr(cwd_pkg::ADDR_PIN_SELECT, 24'h000055);
    chk("pin select reopened", 24'(pin_select_o), 24'h000055);
    // every pll code class, with a spread of postscale codes
    for (int i = 0; i < 6; i++) begin
      ps = 5'(i * 6);
      boot({2'b11, codes[i], 1'b1, 4'b1111, ps});
      chk("pll mode", 24'(pll_multiplier_select_o), 24'(modes[i]));
      chk("pll reserved", 24'(pll_code_bad_o), 24'(bads[i]));
      chk("postscale", 24'(deep_sleep_watchdog_postscale_o), 24'(ps) + 24'd5);
    end
    final_report();
  end
endmodule : config_word_and_id_decode_tb_top
